// File: testbench/smc_top_chk.sv
`timescale 1ns/100ps
`default_nettype none

module smc_top_chk
    import smc_pkg::*;
#(
    parameter int WARMUP_LONG_CYCLES = 65536,
    parameter int WARMUP_SHORT_CYCLES = 16384,
    parameter int CNT_W = 18
) (
    // clock and reset
    input wire logic core_clk_in,
    input wire logic rst_in,
    // watched outputs
    input wire smc_pkg::smc_clk_en_type clk_en_out,
    input wire smc_pkg::smc_port_ctrl_type port_ctrl_out,
    input wire logic machine_cycle_out,
    input wire smc_pkg::smc_mode_type mode_out,
    input wire logic resume_out,
    input wire logic osc_reset_out
);
    logic halted;
    logic run_ok;

    // ----------------------------------------------------------------
    // helpers
    // ----------------------------------------------------------------
    assign halted = (mode_out == SMC_HALT) || (mode_out == SMC_WARMUP);
    // a self reset restarts the cycle count, so it spoils the spacing
    assign run_ok = (mode_out == SMC_RUN) && !osc_reset_out;

    default clocking @(posedge core_clk_in);
    endclocking
    default disable iff (rst_in);

    // ports released and inputs tied low together, only while halted
    property ports_tied;
        (port_ctrl_out.port_oe_n == port_ctrl_out.port_in_zero)
            && (halted || !port_ctrl_out.port_oe_n);
    endproperty

    // ----------------------------------------------------------------
    // assertions
    // ----------------------------------------------------------------
    AST_HALT_GATES: assert property (mode_out == SMC_HALT |-> clk_en_out == 5'h00)
        else $error("clocks enabled in halt");
    AST_WARMUP_OSC: assert property (mode_out == SMC_WARMUP |-> clk_en_out == 5'h10)
        else $error("warm-up clocks wrong");
    AST_WAKE_PIN_Z: assert property (halted |-> port_ctrl_out.wake_pin_oe_n)
        else $error("wake pin driven while halted");
    AST_PORT_TIE: assert property (ports_tied)
        else $error("port control inconsistent");
    AST_RUN_CLK: assert property (mode_out == SMC_RUN |-> clk_en_out == 5'h1F)
        else $error("run mode clocks wrong");
    AST_CORE_SLEEP_CLK: assert property (mode_out == SMC_CORE_SLEEP |-> clk_en_out == 5'h13)
        else $error("core sleep clocks wrong");
    AST_TB_SLEEP_CLK: assert property (mode_out == SMC_TB_SLEEP |-> clk_en_out == 5'h11)
        else $error("time-base sleep clocks wrong");
    AST_MCYC: assert property (machine_cycle_out && run_ok ##1 run_ok [*4] |-> machine_cycle_out && !$past(machine_cycle_out))
        else $error("machine cycle not four clocks");
    AST_RESUME: assert property (mode_out == SMC_WARMUP ##1 mode_out == SMC_RUN |-> resume_out || $past(resume_out))
        else $error("no resume pulse after warm-up");
    AST_OSC_RESET: assert property (osc_reset_out |=> mode_out == SMC_RUN && !osc_reset_out)
        else $error("oscillator stop did not reset");

    COV_CORE: cover property (mode_out == SMC_CORE_SLEEP);
    COV_TB: cover property (mode_out == SMC_TB_SLEEP);
    COV_RESUME: cover property (resume_out);
    COV_OSC: cover property (osc_reset_out);
endmodule

bind smc_top smc_top_chk #(
    .WARMUP_LONG_CYCLES(WARMUP_LONG_CYCLES),
    .WARMUP_SHORT_CYCLES(WARMUP_SHORT_CYCLES),
    .CNT_W(CNT_W)
) i_chk (
    .core_clk_in, .rst_in, .clk_en_out, .port_ctrl_out,
    .machine_cycle_out, .mode_out, .resume_out, .osc_reset_out
);

`default_nettype wire

// File: testbench/smc_wake_src.sv
`timescale 1ns/100ps
`default_nettype none

module smc_wake_src (
    // pins toward the block
    output logic wake_pin_out,
    output logic tb_src_out
);
    initial
    begin
        wake_pin_out = 1'b0;
        tb_src_out = 1'b1;
    end

    // free-running source, odd half period keeps its falling edges off the core clock edges; rising edges land on them
    always #101 tb_src_out = ~tb_src_out;

    // wake pin moves a few ns after the call, not on a clock edge
    task automatic drive_pin(input logic level);
        #3 wake_pin_out = level;
    endtask
endmodule

`default_nettype wire

// File: testbench/testbench.sv
`timescale 1ns/100ps
`default_nettype none

module testbench;
    import smc_pkg::*;

    // ----------------------------------------------------------------
    // set-up
    // ----------------------------------------------------------------
    localparam int LONG_N = 16;
    localparam int SHORT_N = 4;
    localparam logic [31:0] A_HC = {22'h0, REG_IDX_HALT_CTRL, 2'h0};
    localparam logic [31:0] A_OIC = {22'h0, REG_IDX_OSC_IDLE, 2'h0};
    localparam logic [31:0] A_BAD = 32'h000000E8;

    logic core_clk_in = 1'b0;
    logic rst_in, hsel, hwrite, wake_irq, hold, hreadyout, resume, osc_rst, wake_pin, tb_src;
    logic mcyc, hresp;
    logic [2:0] hsize;
    logic rd_dph = 1'b0;
    logic [1:0] htrans, sel;
    logic [31:0] haddr, hwdata, hrdata;
    logic [31:0] expq[$];
    smc_clk_en_type clk_en;
    smc_port_ctrl_type pctl;
    smc_mode_type mode;
    int fail_count = 0;
    int n_tests = 0;
    int seed = 32'h7B939637;
    int res_cnt = 0;
    int mc_cnt = 0;
    int osc_cnt = 0;
    int n, r0, i;

    always #2 core_clk_in = ~core_clk_in;

    smc_top #(.WARMUP_LONG_CYCLES(LONG_N), .WARMUP_SHORT_CYCLES(SHORT_N)) i_dut (
        .core_clk_in(core_clk_in), .rst_in(rst_in), .hsel_in(hsel), .haddr_in(haddr),
        .htrans_in(htrans), .hwrite_in(hwrite), .hsize_in(hsize), .hwdata_in(hwdata),
        .hready_in(hreadyout), .hrdata_out(hrdata), .hreadyout_out(hreadyout), .hresp_out(hresp),
        .wake_pin_in(wake_pin), .timebase_src_in(tb_src), .wake_irq_in(wake_irq),
        .clk_en_out(clk_en), .port_ctrl_out(pctl), .machine_cycle_out(mcyc),
        .mode_out(mode), .resume_out(resume), .osc_reset_out(osc_rst)
    );

    smc_wake_src i_src (.wake_pin_out(wake_pin), .tb_src_out(tb_src));

    // ----------------------------------------------------------------
    // tasks
    // ----------------------------------------------------------------
    task check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp)
        begin
            fail_count++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task test_done;
        if (fail_count == 0 && n_tests > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask

    task timeout;
        check("timeout", 32'h0, 32'h1);
        test_done;
    endtask

    // outputs are registered, so the negedge value is what the next edge samples
    task automatic wait_rdy;
        int k;
        for (k = 0; k < 64; k++)
        begin
            @(negedge core_clk_in);
            if (hreadyout === 1'b1)
                break;
        end
        if (k == 64)
            timeout();
        @(posedge core_clk_in);
    endtask

    task automatic wait_mode(input smc_mode_type m);
        int k;
        for (k = 0; k < 400; k++)
        begin
            @(negedge core_clk_in);
            if (mode === m)
                break;
        end
        if (k == 400)
            timeout();
    endtask

    task bus(input logic wr, input logic [31:0] a, input logic [31:0] d);
        @(posedge core_clk_in);
        hsel <= 1'b1;
        htrans <= 2'h2;
        haddr <= a;
        hwrite <= wr;
        hsize <= 3'h2;
        wait_rdy();
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        wait_rdy();
    endtask

    task rd(input logic [31:0] a, input logic [31:0] exp);
        expq.push_back(exp);
        bus(1'b0, a, 32'h0);
    endtask

    function automatic int wu_n(input logic [1:0] s);
        case (s)
            2'h0: return 3 * LONG_N;
            2'h1: return LONG_N;
            2'h2: return 3 * SHORT_N;
            default: return SHORT_N;
        endcase
    endfunction

    // ----------------------------------------------------------------
    // monitor
    // ----------------------------------------------------------------
    always @(posedge core_clk_in)
        if (hreadyout)
            rd_dph <= hsel && htrans[1] && !hwrite;

    // each read result is held against the oldest note
    always @(negedge core_clk_in)
    begin
        if (rd_dph && hreadyout === 1'b1)
        begin
            check("hrdata", hrdata, (expq.size() > 0) ? expq.pop_front() : 32'hFFFFFFFF);
            check("hresp", {31'h0, hresp}, 32'h0);
        end
        if (mcyc === 1'b1)
            mc_cnt++;
        if (resume === 1'b1)
            res_cnt++;
        if (osc_rst === 1'b1)
            osc_cnt++;
    end

    // ----------------------------------------------------------------
    // main sequence
    // ----------------------------------------------------------------
    initial
    begin
        rst_in = 1'b1;
        hsel = 1'b0;
        htrans = 2'h0;
        haddr = 32'h0;
        hwrite = 1'b0;
        hsize = 3'h0;
        hwdata = 32'h0;
        wake_irq = 1'b0;
        repeat (8) @(posedge core_clk_in);
        rst_in <= 1'b0;
        rd(A_HC, 32'h00);
        rd(A_OIC, 32'h80);
        @(negedge core_clk_in);
        check("mode", {29'h0, mode}, {29'h0, SMC_RUN});
        // one machine-cycle pulse per four clocks in run mode
        @(posedge core_clk_in);
        r0 = mc_cnt;
        repeat (16) @(posedge core_clk_in);
        check("mcyc", 32'(mc_cnt - r0), 32'h4);
        bus(1'b1, A_HC, 32'h5F);
        rd(A_HC, 32'h5C);
        bus(1'b1, A_OIC, 32'h8B);
        rd(A_OIC, 32'h80);
        bus(1'b1, A_BAD, $random(seed));
        rd(A_BAD, 32'h0);
        // second pass sets both sleep bits, which must fall back to core sleep
        for (i = 0; i < 2; i++)
        begin
            bus(1'b1, A_OIC, (i == 0) ? 32'h90 : 32'h94);
            wait_mode(SMC_CORE_SLEEP);
            repeat (3) @(negedge core_clk_in);
            check("core_mode", {29'h0, mode}, {29'h0, SMC_CORE_SLEEP});
            @(posedge core_clk_in);
            wake_irq <= 1'b1;
            wait_mode(SMC_RUN);
            @(posedge core_clk_in);
            wake_irq <= 1'b0;
            rd(A_OIC, 32'h80);
        end
        bus(1'b1, A_OIC, 32'h84);
        wait_mode(SMC_TB_SLEEP);
        wait_mode(SMC_RUN);
        rd(A_OIC, 32'h80);
        // edge wake, every warm-up code, shortest first
        for (i = 3; i >= 0; i--)
        begin
            sel = 2'(i);
            hold = 1'($random(seed));
            bus(1'b1, A_HC, {24'h0, 1'b1, 2'h0, hold, sel, 2'h0});
            wait_mode(SMC_HALT);
            check("ports", {29'h0, pctl}, {29'h0, ~hold, ~hold, 1'b1});
            r0 = res_cnt;
            i_src.drive_pin(1'b1);
            wait_mode(SMC_WARMUP);
            for (n = 0; n < 400 && mode === SMC_WARMUP; n++)
                @(negedge core_clk_in);
            check("run", {29'h0, mode}, {29'h0, SMC_RUN});
            i_src.drive_pin(1'b0);
            repeat (2) @(negedge core_clk_in);
            check("resume", 32'(res_cnt - r0), 32'h1);
            check("warmup", 32'(n), 32'(wu_n(sel)));
            rd(A_HC, {24'h0, 3'h0, hold, sel, 2'h0});
        end
        // level wake: pin already high goes straight to warm-up
        i_src.drive_pin(1'b1);
        repeat (4) @(posedge core_clk_in);
        bus(1'b1, A_HC, 32'hC0);
        repeat (3) @(negedge core_clk_in);
        check("level_high", {29'h0, mode}, {29'h0, SMC_WARMUP});
        wait_mode(SMC_RUN);
        i_src.drive_pin(1'b0);
        repeat (4) @(posedge core_clk_in);
        bus(1'b1, A_HC, 32'hC0);
        wait_mode(SMC_HALT);
        repeat (8) @(negedge core_clk_in);
        check("level_low", {29'h0, mode}, {29'h0, SMC_HALT});
        i_src.drive_pin(1'b1);
        wait_mode(SMC_WARMUP);
        wait_mode(SMC_RUN);
        i_src.drive_pin(1'b0);
        // reset pin while halted
        bus(1'b1, A_HC, 32'h8C);
        wait_mode(SMC_HALT);
        @(posedge core_clk_in);
        rst_in <= 1'b1;
        repeat (3) @(posedge core_clk_in);
        rst_in <= 1'b0;
        @(negedge core_clk_in);
        check("reset_mode", {29'h0, mode}, {29'h0, SMC_RUN});
        rd(A_HC, 32'h00);
        // stopping the oscillator resets the block
        bus(1'b1, A_HC, 32'h50);
        r0 = osc_cnt;
        bus(1'b1, A_OIC, 32'h00);
        repeat (3) @(negedge core_clk_in);
        check("osc_reset", 32'(osc_cnt - r0), 32'h1);
        rd(A_HC, 32'h00);
        rd(A_OIC, 32'h80);
        repeat (4) @(negedge core_clk_in);
        test_done;
    end
endmodule

`default_nettype wire

// File: verilog/smc_pin_sync.sv
`timescale 1ns/100ps
`default_nettype none

module smc_pin_sync #(
    parameter int WIDTH = 2
) (
    // clock and reset
    input wire logic core_clk_in,
    input wire logic rst_in,
    // asynchronous pins
    input wire logic [WIDTH-1:0] pin_in,
    // synchronised level and edges
    output logic [WIDTH-1:0] level_out,
    output logic [WIDTH-1:0] rise_out,
    output logic [WIDTH-1:0] fall_out
);
    logic [WIDTH-1:0] meta;
    logic [WIDTH-1:0] stable;
    logic [WIDTH-1:0] prev;

    // edge detect compares the second stage with the history stage, never the first
    always_comb
    begin
        level_out = stable;
        rise_out = stable & ~prev;
        fall_out = ~stable & prev;
    end

    // two-flop synchroniser plus one history stage
    always_ff @(posedge core_clk_in)
    begin
        if (rst_in)
        begin
            meta <= '0;
            stable <= '0;
            prev <= '0;
        end
        else
        begin
            meta <= pin_in;
            stable <= meta;
            prev <= stable;
        end
    end

endmodule

`default_nettype wire

// File: verilog/smc_pkg.sv
// Operation
// - deep halt stops oscillator, keeps state
// - halt by register write, wake pin releases
// - after warm-up, resume at next instruction
// - halt start bit 1 enters deep halt
// - wake method: 0 edge, 1 level
// - port hold: 0 high impedance, 1 kept
// - warm-up select picks one of four counts
// - reset during deep halt returns run mode
// - undefined register bits read back as zero
// - no port hold: port inputs forced low
// - wake pin bit always high impedance halted
// - clearing oscillator enable resets device
// - core sleep stops cpu and watchdog
// - timing generator clocks all peripherals normally
// - time-base sleep ends on source falling edge
// - core sleep bit clears on release
// - timing-generator halt bit clears on release
// - machine cycle four clocks; sleep clock gating
// - timing-generator halt enters time-base sleep
// - divider cleared at halt start and release
// - reset starts in run mode

package smc_pkg;

    // ----------------------------------------------------------------
    // register map: indices, byte address is four times the index
    // ----------------------------------------------------------------
    localparam logic [7:0] REG_IDX_HALT_CTRL = 8'h38;
    localparam logic [7:0] REG_IDX_OSC_IDLE = 8'h39;
    localparam int HADDR_IDX_LSB = 2;
    localparam int HADDR_IDX_MSB = 9;

    // ----------------------------------------------------------------
    // halt_control fields
    // ----------------------------------------------------------------
    localparam int HC_HALT_BIT = 7;
    localparam int HC_WAKE_METHOD_BIT = 6;
    localparam int HC_PORT_HOLD_BIT = 4;
    localparam int HC_WARMUP_LSB = 2;
    localparam logic [7:0] HC_RESET = 8'h00;
    localparam logic [7:0] HC_MASK = 8'hDC;

    // ----------------------------------------------------------------
    // osc_idle_control fields
    // ----------------------------------------------------------------
    localparam int OIC_OSC_EN_BIT = 7;
    localparam int OIC_CORE_SLEEP_BIT = 4;
    localparam int OIC_TG_HALT_BIT = 2;
    localparam logic [7:0] OIC_RESET = 8'h80;
    localparam logic [7:0] OIC_MASK = 8'h94;

    // ----------------------------------------------------------------
    // warm-up select codes and timing
    // ----------------------------------------------------------------
    localparam logic [1:0] WU_3X_LONG = 2'h0;
    localparam logic [1:0] WU_LONG = 2'h1;
    localparam logic [1:0] WU_3X_SHORT = 2'h2;
    localparam logic [1:0] WU_SHORT = 2'h3;
    localparam int WU_TRIPLE = 3;
    localparam logic [1:0] MCYC_LAST = 2'h3;

    // ----------------------------------------------------------------
    // bus encodings
    // ----------------------------------------------------------------
    localparam int HTRANS_ACTIVE_BIT = 1;
    localparam logic HRESP_OKAY = 1'b0;

    // ----------------------------------------------------------------
    // types
    // ----------------------------------------------------------------
    typedef enum logic [2:0] {
        SMC_RUN,
        SMC_CORE_SLEEP,
        SMC_TB_SLEEP,
        SMC_HALT,
        SMC_WARMUP
    } smc_mode_type;

    typedef struct packed {
        logic osc;
        logic cpu;
        logic wdt;
        logic periph;
        logic timebase_timer;
    } smc_clk_en_type;

    typedef struct packed {
        logic port_oe_n;
        logic port_in_zero;
        logic wake_pin_oe_n;
    } smc_port_ctrl_type;

endpackage

// File: verilog/smc_top.sv
// Local design decision: register access over AHB-Lite.
`timescale 1ns/100ps
`default_nettype none

module smc_top #(
    parameter int WARMUP_LONG_CYCLES = 65536,
    parameter int WARMUP_SHORT_CYCLES = 16384,
    parameter int CNT_W = 18
) (
    // clock and reset
    input wire logic core_clk_in,
    input wire logic rst_in,
    // ahb-lite slave
    input wire logic hsel_in,
    input wire logic [31:0] haddr_in,
    input wire logic [1:0] htrans_in,
    input wire logic hwrite_in,
    input wire logic [2:0] hsize_in,
    input wire logic [31:0] hwdata_in,
    input wire logic hready_in,
    output logic [31:0] hrdata_out,
    output logic hreadyout_out,
    output logic hresp_out,
    // wake sources
    input wire logic wake_pin_in,
    input wire logic timebase_src_in,
    input wire logic wake_irq_in,
    // clock gating and port control
    output smc_pkg::smc_clk_en_type clk_en_out,
    output smc_pkg::smc_port_ctrl_type port_ctrl_out,
    output logic machine_cycle_out,
    // mode status
    output smc_pkg::smc_mode_type mode_out,
    output logic resume_out,
    output logic osc_reset_out
);
    import smc_pkg::*;

    // ----------------------------------------------------------------
    // pin synchronisers
    // ----------------------------------------------------------------
    logic [1:0] pin_level;
    logic [1:0] pin_rise;
    logic [1:0] pin_fall;
    logic wake_level;
    logic wake_rise;
    logic tb_fall;

    smc_pin_sync #(
        .WIDTH(2)
    ) u_pin_sync (
        .core_clk_in(core_clk_in),
        .rst_in(rst_in),
        .pin_in({timebase_src_in, wake_pin_in}),
        .level_out(pin_level),
        .rise_out(pin_rise),
        .fall_out(pin_fall)
    );

    // bit 0 is the wake pin, bit 1 the time-base source
    assign wake_level = pin_level[0];
    assign wake_rise = pin_rise[0];
    assign tb_fall = pin_fall[1];

    // ----------------------------------------------------------------
    // bus slave state
    // ----------------------------------------------------------------
    logic wr_pend;
    logic rd_pend;
    logic [7:0] dp_idx;
    logic next_wr_pend;
    logic next_rd_pend;
    logic [7:0] next_dp_idx;
    logic [31:0] next_hrdata;
    logic next_hreadyout;
    logic addr_phase;

    // ----------------------------------------------------------------
    // control state
    // ----------------------------------------------------------------
    logic [7:0] halt_control;
    logic [7:0] osc_idle_control;
    logic [CNT_W-1:0] warm_cnt;
    logic [1:0] mcyc_cnt;
    logic [7:0] next_halt_control;
    logic [7:0] next_osc_idle_control;
    logic [CNT_W-1:0] next_warm_cnt;
    logic [1:0] next_mcyc_cnt;
    smc_mode_type next_mode;
    smc_clk_en_type next_clk_en;
    smc_port_ctrl_type next_port_ctrl;
    logic next_machine_cycle;
    logic next_resume;
    logic next_osc_reset;
    logic wr_halt_ctrl;
    logic wr_osc_idle;
    logic halted;
    logic [7:0] wdata;

    // warm-up length from the two-bit select
    function automatic logic [CNT_W-1:0] warmup_target(input logic [1:0] sel);
        logic [CNT_W-1:0] t;
        t = CNT_W'(WARMUP_SHORT_CYCLES);
        unique case (sel)
            WU_3X_LONG: t = CNT_W'(WU_TRIPLE * WARMUP_LONG_CYCLES);
            WU_LONG: t = CNT_W'(WARMUP_LONG_CYCLES);
            WU_3X_SHORT: t = CNT_W'(WU_TRIPLE * WARMUP_SHORT_CYCLES);
            WU_SHORT: t = CNT_W'(WARMUP_SHORT_CYCLES);
        endcase
        return t;
    endfunction

    // ----------------------------------------------------------------
    // bus slave: writes zero-wait, reads one wait state
    // ----------------------------------------------------------------
    assign addr_phase = hsel_in & htrans_in[HTRANS_ACTIVE_BIT] & hready_in;

    // reads wait one cycle so a write in the preceding data phase lands first
    always_comb
    begin
        next_wr_pend = 1'b0;
        next_rd_pend = 1'b0;
        next_dp_idx = dp_idx;
        next_hrdata = hrdata_out;
        next_hreadyout = 1'b1;
        if (addr_phase)
        begin
            next_dp_idx = haddr_in[HADDR_IDX_MSB:HADDR_IDX_LSB];
            next_wr_pend = hwrite_in;
            next_rd_pend = ~hwrite_in;
            next_hreadyout = hwrite_in;
        end
        if (rd_pend)
        begin
            // undefined and unmapped bits read as zero
            if (dp_idx == REG_IDX_HALT_CTRL)
                next_hrdata = {24'h000000, halt_control & HC_MASK};
            else if (dp_idx == REG_IDX_OSC_IDLE)
                next_hrdata = {24'h000000, osc_idle_control & OIC_MASK};
            else
                next_hrdata = 32'h00000000;
        end
    end

    // bus registers
    always_ff @(posedge core_clk_in)
    begin
        if (rst_in)
        begin
            wr_pend <= 1'b0;
            rd_pend <= 1'b0;
            dp_idx <= 8'h00;
            hrdata_out <= 32'h00000000;
            hreadyout_out <= 1'b1;
            hresp_out <= HRESP_OKAY;
        end
        else
        begin
            wr_pend <= next_wr_pend;
            rd_pend <= next_rd_pend;
            dp_idx <= next_dp_idx;
            hrdata_out <= next_hrdata;
            hreadyout_out <= next_hreadyout;
            hresp_out <= HRESP_OKAY;
        end
    end

    // ----------------------------------------------------------------
    // register writes and mode sequencing
    // ----------------------------------------------------------------
    assign wr_halt_ctrl = wr_pend & (dp_idx == REG_IDX_HALT_CTRL);
    assign wr_osc_idle = wr_pend & (dp_idx == REG_IDX_OSC_IDLE);
    assign wdata = hwdata_in[7:0];

    // hardware clears are applied first so a software write in the same cycle wins
    always_comb
    begin
        next_halt_control = halt_control;
        next_osc_idle_control = osc_idle_control;
        next_mode = mode_out;
        next_warm_cnt = warm_cnt;
        next_resume = 1'b0;
        next_osc_reset = 1'b0;
        unique case (mode_out)
            SMC_RUN:
            begin
                if (halt_control[HC_HALT_BIT])
                begin
                    // level mode with pin already high skips straight to warm-up
                    next_warm_cnt = '0;
                    if (halt_control[HC_WAKE_METHOD_BIT] & wake_level)
                        next_mode = SMC_WARMUP;
                    else
                        next_mode = SMC_HALT;
                end
                else if (osc_idle_control[OIC_CORE_SLEEP_BIT])
                    next_mode = SMC_CORE_SLEEP;
                else if (osc_idle_control[OIC_TG_HALT_BIT])
                    next_mode = SMC_TB_SLEEP;
            end
            SMC_CORE_SLEEP:
            begin
                if (wake_irq_in)
                begin
                    next_mode = SMC_RUN;
                    next_osc_idle_control[OIC_CORE_SLEEP_BIT] = 1'b0;
                end
            end
            SMC_TB_SLEEP:
            begin
                // the source edge is asynchronous, so the sleep may run short
                if (tb_fall)
                begin
                    next_mode = SMC_RUN;
                    next_osc_idle_control[OIC_TG_HALT_BIT] = 1'b0;
                end
            end
            SMC_HALT:
            begin
                // edge mode needs a fresh rising edge, level mode a high pin
                if (halt_control[HC_WAKE_METHOD_BIT] ? wake_level : wake_rise)
                begin
                    next_mode = SMC_WARMUP;
                    next_warm_cnt = '0;
                end
            end
            SMC_WARMUP:
            begin
                next_warm_cnt = warm_cnt + CNT_W'(1);
                if (next_warm_cnt == warmup_target(halt_control[HC_WARMUP_LSB +: 2]))
                begin
                    next_mode = SMC_RUN;
                    next_warm_cnt = '0;
                    next_halt_control[HC_HALT_BIT] = 1'b0;
                    next_resume = 1'b1;
                end
            end
        endcase
        if (wr_halt_ctrl)
            next_halt_control = wdata & HC_MASK;
        if (wr_osc_idle)
        begin
            next_osc_idle_control = wdata & OIC_MASK;
            // both sleep bits at once: core sleep takes precedence
            if (wdata[OIC_CORE_SLEEP_BIT])
                next_osc_idle_control[OIC_TG_HALT_BIT] = 1'b0;
            // stopping the oscillator raises osc_reset_out on the next edge and resets the device on the edge after
            if (~wdata[OIC_OSC_EN_BIT])
                next_osc_reset = 1'b1;
        end
    end

    // ----------------------------------------------------------------
    // clock gating, machine cycle and port control
    // ----------------------------------------------------------------
    assign halted = (next_mode == SMC_HALT) | (next_mode == SMC_WARMUP);

    // outputs are decoded from the next mode so they flip with the mode flop
    always_comb
    begin
        next_clk_en = '0;
        unique case (next_mode)
            SMC_RUN:
            begin
                next_clk_en = '1;
            end
            SMC_CORE_SLEEP:
            begin
                next_clk_en.osc = 1'b1;
                next_clk_en.periph = 1'b1;
                next_clk_en.timebase_timer = 1'b1;
            end
            SMC_TB_SLEEP:
            begin
                next_clk_en.osc = 1'b1;
                next_clk_en.timebase_timer = 1'b1;
            end
            SMC_HALT:
            begin
                next_clk_en = '0;
            end
            SMC_WARMUP:
            begin
                next_clk_en.osc = 1'b1; // oscillator restarts, all else halted
            end
        endcase
        // machine cycle is four core clocks, cleared across a halt
        next_mcyc_cnt = mcyc_cnt;
        if (halted)
            next_mcyc_cnt = 2'h0;
        else if (next_clk_en.cpu | next_clk_en.periph)
            next_mcyc_cnt = mcyc_cnt + 2'h1;
        next_machine_cycle = (~halted) & (next_clk_en.cpu | next_clk_en.periph)
            & (mcyc_cnt == MCYC_LAST);
        // port behaviour while halted; the wake pin ignores the hold bit
        next_port_ctrl.port_oe_n = halted & ~next_halt_control[HC_PORT_HOLD_BIT];
        next_port_ctrl.port_in_zero = halted & ~next_halt_control[HC_PORT_HOLD_BIT];
        next_port_ctrl.wake_pin_oe_n = halted;
    end

    // control registers; a pin reset or oscillator-off reset lands in run mode
    always_ff @(posedge core_clk_in)
    begin
        if (rst_in | osc_reset_out)
        begin
            halt_control <= HC_RESET;
            osc_idle_control <= OIC_RESET;
            mode_out <= SMC_RUN;
            warm_cnt <= '0;
            mcyc_cnt <= 2'h0;
            clk_en_out <= '1;
            port_ctrl_out <= '0;
            machine_cycle_out <= 1'b0;
            resume_out <= 1'b0;
            osc_reset_out <= 1'b0;
        end
        else
        begin
            halt_control <= next_halt_control;
            osc_idle_control <= next_osc_idle_control;
            mode_out <= next_mode;
            warm_cnt <= next_warm_cnt;
            mcyc_cnt <= next_mcyc_cnt;
            clk_en_out <= next_clk_en;
            port_ctrl_out <= next_port_ctrl;
            machine_cycle_out <= next_machine_cycle;
            resume_out <= next_resume;
            osc_reset_out <= next_osc_reset;
        end
    end

endmodule

`default_nettype wire
